// [hdl/bram_pkg.sv]
// shared constants, types and helpers for the embedded block ram
package bram_pkg;

  // storage size and widths
  localparam int ARRAY_BITS = 9216;
  localparam int MAX_W      = 36;
  localparam int ADDR_W     = 13;
  localparam int BIT_W      = 14;
  localparam int CNT_W      = 15;

  // organisation figures, bits per word and words per port
  localparam int BITS_W1   = 1;
  localparam int BITS_W2   = 2;
  localparam int BITS_W4   = 4;
  localparam int BITS_W9   = 9;
  localparam int BITS_W18  = 18;
  localparam int BITS_W36  = 36;
  localparam int DEPTH_W1  = 8192;
  localparam int DEPTH_W2  = 4096;
  localparam int DEPTH_W4  = 2048;
  localparam int DEPTH_W9  = 1024;
  localparam int DEPTH_W18 = 512;
  localparam int DEPTH_W36 = 256;

  typedef enum logic [1:0] {
    BRAM_MODE_SINGLE,
    BRAM_MODE_TRUE_DUAL,
    BRAM_MODE_PSEUDO_DUAL,
    BRAM_MODE_FIFO
  } bram_mode_t;

  typedef enum logic [2:0] {
    BRAM_W1,
    BRAM_W2,
    BRAM_W4,
    BRAM_W9,
    BRAM_W18,
    BRAM_W36
  } bram_width_t;

  // one port request as presented by fabric logic
  typedef struct packed {
    logic              ce;
    logic              we;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [MAX_W-1:0]  wdata;
  } bram_req_t;

  // input register contents of one port
  typedef struct packed {
    logic             valid;
    logic             we;
    logic [BIT_W-1:0] base;
    logic [MAX_W-1:0] wdata;
  } bram_stage_t;

  typedef struct packed {
    bram_stage_t      a;
    bram_stage_t      b;
    logic [MAX_W-1:0] rd_a;
    logic [MAX_W-1:0] rd_b;
    logic             rv_a;
    logic             rv_b;
    logic [BIT_W-1:0] wptr;
    logic [BIT_W-1:0] rptr;
    logic [CNT_W-1:0] count;
  } bram_state_t;

  typedef struct packed {
    logic             valid;
    logic [MAX_W-1:0] data;
  } bram_ostage_t;

  function automatic int width_bits(bram_width_t w);
    int r;
    r = BITS_W1;
    unique case (w)
      BRAM_W1:  r = BITS_W1;
      BRAM_W2:  r = BITS_W2;
      BRAM_W4:  r = BITS_W4;
      BRAM_W9:  r = BITS_W9;
      BRAM_W18: r = BITS_W18;
      BRAM_W36: r = BITS_W36;
      default:  r = BITS_W1;
    endcase
    return r;
  endfunction

  function automatic int depth_words(bram_width_t w);
    int r;
    r = DEPTH_W1;
    unique case (w)
      BRAM_W1:  r = DEPTH_W1;
      BRAM_W2:  r = DEPTH_W2;
      BRAM_W4:  r = DEPTH_W4;
      BRAM_W9:  r = DEPTH_W9;
      BRAM_W18: r = DEPTH_W18;
      BRAM_W36: r = DEPTH_W36;
      default:  r = DEPTH_W1;
    endcase
    return r;
  endfunction

endpackage

// [hdl/bram_out_stage.sv]
// optional read data output register of one port
module bram_out_stage (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      port_rst,
  input  wire logic                      reg_en,
  input  wire logic                      in_valid,
  input  wire logic [bram_pkg::MAX_W-1:0] in_data,
  output logic                           out_valid,
  output logic      [bram_pkg::MAX_W-1:0] out_data
);

  bram_pkg::bram_ostage_t s_r;
  bram_pkg::bram_ostage_t s_nxt;

  always_comb begin
    s_nxt.valid = in_valid;
    s_nxt.data  = in_data;
    if (port_rst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // the extra stage costs one clock of latency but eases fabric timing
  assign out_valid = reg_en ? s_r.valid : in_valid;
  assign out_data  = reg_en ? s_r.data : in_data;

  a_out_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_en && in_valid && !port_rst) ##1 reg_en |-> out_valid && out_data == $past(in_data))
    else $error("registered read data not one clock late");

endmodule // bram_out_stage

// [hdl/bram_block.sv]
// embedded 9-kbit block ram: single, true dual, pseudo dual port and fifo modes

// Overview of operation
// - 9-kbit array with input and output registers
// - modes: single, true dual, pseudo dual, fifo
// - widths 1,2,4,9,18,36 outside true dual
// - true dual port limited to 18 bits wide
// - each port has its own width
// - bits packed linearly, lsb first, every port
// - contents preloaded before user operation starts
// - address and write data registered at array
// - optional output register adds one clock
module bram_block #(
  parameter logic [bram_pkg::ARRAY_BITS-1:0] INIT_BITS = '0
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire bram_pkg::bram_mode_t        mode,
  input  wire bram_pkg::bram_width_t       width_a,
  input  wire bram_pkg::bram_width_t       width_b,
  input  wire logic                        out_reg_en,
  input  wire bram_pkg::bram_req_t         req_a,
  input  wire bram_pkg::bram_req_t         req_b,
  output logic      [bram_pkg::MAX_W-1:0]   rdata_a,
  output logic                             rvalid_a,
  output logic      [bram_pkg::MAX_W-1:0]   rdata_b,
  output logic                             rvalid_b,
  output logic                             fifo_full,
  output logic                             fifo_empty
);

  bram_pkg::bram_state_t s_r;
  bram_pkg::bram_state_t s_nxt;
  logic                  mem [0:bram_pkg::ARRAY_BITS-1];

  bram_pkg::bram_width_t eff_wa;
  bram_pkg::bram_width_t eff_wb;
  int                    wa;
  int                    wb;
  int                    cap;
  int                    lim;
  logic                  is_fifo;
  logic                  push_ok;
  logic                  pop_ok;
  logic                  wr_go_a;
  logic                  wr_go_b;
  logic                  rd_go_a;
  logic                  rd_go_b;
  logic [bram_pkg::BIT_W-1:0] wbase_a;
  logic [bram_pkg::BIT_W-1:0] rbase_b;

  function automatic int wrap(int v, int l);
    return (v >= l) ? v - l : v;
  endfunction

  // word index to first bit: word n starts at bit n*width
  function automatic logic [bram_pkg::BIT_W-1:0] bit_base(
    logic [bram_pkg::ADDR_W-1:0] addr, bram_pkg::bram_width_t w);
    int b;
    b = (int'(addr) % bram_pkg::depth_words(w)) * bram_pkg::width_bits(w);
    return bram_pkg::BIT_W'(b);
  endfunction

  // the 36-bit organisation has no room for two ports; fall back to 18
  always_comb begin
    eff_wa = width_a;
    eff_wb = width_b;
    if (mode == bram_pkg::BRAM_MODE_TRUE_DUAL && width_a == bram_pkg::BRAM_W36) begin
      eff_wa = bram_pkg::BRAM_W18;
    end
    if (mode == bram_pkg::BRAM_MODE_TRUE_DUAL && width_b == bram_pkg::BRAM_W36) begin
      eff_wb = bram_pkg::BRAM_W18;
    end
  end

  assign wa      = bram_pkg::width_bits(eff_wa);
  assign wb      = bram_pkg::width_bits(eff_wb);
  assign is_fifo = (mode == bram_pkg::BRAM_MODE_FIFO);
  assign cap     = bram_pkg::depth_words(eff_wa) * wa;
  assign lim     = is_fifo ? cap : bram_pkg::ARRAY_BITS;

  // fifo: port a pushes, port b pops; flags judged on the registered request
  assign push_ok = is_fifo && s_r.a.valid && s_r.a.we && (int'(s_r.count) + wa <= cap);
  assign pop_ok  = is_fifo && s_r.b.valid && (int'(s_r.count) >= wb);

  // mode steering of each port
  assign wr_go_a = is_fifo ? push_ok : (s_r.a.valid && s_r.a.we);
  assign wr_go_b = (mode == bram_pkg::BRAM_MODE_TRUE_DUAL) && s_r.b.valid && s_r.b.we;
  assign rd_go_a = (mode == bram_pkg::BRAM_MODE_SINGLE
                    || mode == bram_pkg::BRAM_MODE_TRUE_DUAL) && s_r.a.valid;
  assign rd_go_b = is_fifo ? pop_ok
                 : ((mode == bram_pkg::BRAM_MODE_TRUE_DUAL
                     || mode == bram_pkg::BRAM_MODE_PSEUDO_DUAL) && s_r.b.valid);
  assign wbase_a = is_fifo ? s_r.wptr : s_r.a.base;
  assign rbase_b = is_fifo ? s_r.rptr : s_r.b.base;

  always_comb begin
    logic [bram_pkg::MAX_W-1:0] rda;
    logic [bram_pkg::MAX_W-1:0] rdb;
    int                         cnt;
    rda = '0;
    rdb = '0;
    cnt = int'(s_r.count);
    s_nxt = s_r;
    // input registers: the array only ever sees clocked address and data
    s_nxt.a.valid = req_a.ce;
    s_nxt.a.we    = req_a.we;
    s_nxt.a.base  = bit_base(req_a.addr, eff_wa);
    s_nxt.a.wdata = req_a.wdata;
    s_nxt.b.valid = req_b.ce && (mode != bram_pkg::BRAM_MODE_SINGLE);
    s_nxt.b.we    = req_b.we;
    s_nxt.b.base  = bit_base(req_b.addr, eff_wb);
    s_nxt.b.wdata = req_b.wdata;
    // read old contents: a read meeting a write to the same bit sees old data
    for (int i = 0; i < bram_pkg::MAX_W; i++) begin
      if (i < wa) begin
        rda[i] = mem[wrap(int'(s_r.a.base) + i, lim)];
      end
      if (i < wb) begin
        rdb[i] = mem[wrap(int'(rbase_b) + i, lim)];
      end
    end
    s_nxt.rv_a = rd_go_a;
    s_nxt.rv_b = rd_go_b;
    if (rd_go_a) begin
      s_nxt.rd_a = rda;
    end
    if (rd_go_b) begin
      s_nxt.rd_b = rdb;
    end
    if (req_a.rst) begin
      s_nxt.rd_a = '0;
      s_nxt.rv_a = 1'b0;
    end
    if (req_b.rst) begin
      s_nxt.rd_b = '0;
      s_nxt.rv_b = 1'b0;
    end
    // fifo bookkeeping in bit units so mixed port widths share one count
    if (push_ok) begin
      s_nxt.wptr = bram_pkg::BIT_W'(wrap(int'(s_r.wptr) + wa, cap));
      cnt = cnt + wa;
    end
    if (pop_ok) begin
      s_nxt.rptr = bram_pkg::BIT_W'(wrap(int'(s_r.rptr) + wb, cap));
      cnt = cnt - wb;
    end
    s_nxt.count = bram_pkg::CNT_W'(cnt);
    if (!is_fifo) begin
      s_nxt.wptr  = '0;
      s_nxt.rptr  = '0;
      s_nxt.count = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // preload at configuration; rst_n leaves the contents alone
  initial begin
    for (int i = 0; i < bram_pkg::ARRAY_BITS; i++) begin
      mem[i] = INIT_BITS[i];
    end
  end

  // within each bit offset port b is written last, so in a same-bit collision the higher offset wins and port b wins at equal offsets
  // plain always: the preload process also writes this array
  always @(posedge mclk) begin
    for (int i = 0; i < bram_pkg::MAX_W; i++) begin
      if (wr_go_a && i < wa) begin
        mem[wrap(int'(wbase_a) + i, lim)] <= s_r.a.wdata[i];
      end
      if (wr_go_b && i < wb) begin
        mem[wrap(int'(s_r.b.base) + i, lim)] <= s_r.b.wdata[i];
      end
    end
  end

  assign fifo_full  = is_fifo && (int'(s_r.count) + wa > cap);
  assign fifo_empty = is_fifo && (int'(s_r.count) < wb);

  bram_out_stage u_out_a (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .port_rst  (req_a.rst),
    .reg_en    (out_reg_en),
    .in_valid  (s_r.rv_a),
    .in_data   (s_r.rd_a),
    .out_valid (rvalid_a),
    .out_data  (rdata_a)
  );

  bram_out_stage u_out_b (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .port_rst  (req_b.rst),
    .reg_en    (out_reg_en),
    .in_valid  (s_r.rv_b),
    .in_data   (s_r.rd_b),
    .out_valid (rvalid_b),
    .out_data  (rdata_b)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_read_a_req;
    req_a.ce && !req_a.rst && (mode == bram_pkg::BRAM_MODE_SINGLE);
  endsequence

  sequence s_read_a_bypass;
    (s_read_a_req and !out_reg_en) ##1 !req_a.rst && !out_reg_en ##1 !req_a.rst && !out_reg_en;
  endsequence

  // an idle cycle first, so the answer edge is the first one with valid high
  sequence s_read_a_registered;
    !req_a.ce ##1 (s_read_a_req and out_reg_en) ##1 !req_a.rst && out_reg_en
      ##1 !req_a.rst && out_reg_en ##1 !req_a.rst && out_reg_en;
  endsequence

  a_tdp_width_cap: assert property (
    mode == bram_pkg::BRAM_MODE_TRUE_DUAL |-> wa <= bram_pkg::BITS_W18 && wb <= bram_pkg::BITS_W18)
    else $error("true dual port ran wider than 18 bits");

  a_input_capture: assert property (
    req_a.ce |=> s_r.a.valid && s_r.a.wdata == $past(req_a.wdata))
    else $error("port a request not held in input register");

  a_read_bypass: assert property (
    s_read_a_bypass |-> rvalid_a)
    else $error("bypassed read data not two clocks after request");

  a_read_registered: assert property (
    s_read_a_registered |-> rvalid_a && !$past(rvalid_a))
    else $error("registered read data not three clocks after request");

  a_single_b_idle: assert property (
    mode == bram_pkg::BRAM_MODE_SINGLE |=> !wr_go_b && !rd_go_b)
    else $error("port b active in single port mode");

  a_pseudo_split: assert property (
    mode == bram_pkg::BRAM_MODE_PSEUDO_DUAL |-> !rd_go_a && !wr_go_b)
    else $error("pseudo dual port direction violated");

  a_full_drop: assert property (
    is_fifo && fifo_full && s_r.a.valid && !pop_ok ##1 is_fifo |-> $stable(s_r.wptr))
    else $error("write accepted while fifo full");

  a_empty_drop: assert property (
    is_fifo && fifo_empty && s_r.b.valid ##1 is_fifo |-> $stable(s_r.rptr))
    else $error("read accepted while fifo empty");

  a_fifo_bound: assert property (
    is_fifo |-> int'(s_r.count) <= cap)
    else $error("fifo count beyond capacity");

  a_map_bound: assert property (
    s_r.a.valid && !is_fifo |-> int'(s_r.a.base) + wa <= bram_pkg::ARRAY_BITS)
    else $error("port a word runs past the array");

endmodule // bram_block

// [testbench/bram_fabric.sv]
// fabric side model: presents the requests of both ports
module bram_fabric (
  output bram_pkg::bram_req_t req_a,
  output bram_pkg::bram_req_t req_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_a = '0;
    req_b = '0;
  end

  // called just after a falling edge; the request stands until the next call
  task automatic drive(input logic p, input logic we, input logic [12:0] ad,
                       input logic [35:0] wd);
    bram_pkg::bram_req_t r;
    r = '{ce: 1'b1, we: we, rst: 1'b0, addr: ad, wdata: wd};
    if (p) req_b = r;
    else req_a = r;
  endtask

  // released lines flip, so a stale address or data never looks live
  task automatic rel();
    req_a = '{ce: 1'b0, we: 1'b0, rst: 1'b0, addr: ~req_a.addr, wdata: ~req_a.wdata};
    req_b = '{ce: 1'b0, we: 1'b0, rst: 1'b0, addr: ~req_b.addr, wdata: ~req_b.wdata};
  endtask
endmodule // bram_fabric

// [testbench/tb_top.sv]
// self-checking bench of the embedded block ram
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [35:0] INIT_LOW = 36'h00000A5C3;
  localparam int          WB[6]    = '{1, 2, 4, 9, 18, 36};

  logic                  mclk  = 1'b0;
  logic                  rst_n = 1'b0;
  bram_pkg::bram_mode_t  mode  = bram_pkg::BRAM_MODE_SINGLE;
  bram_pkg::bram_width_t wa    = bram_pkg::BRAM_W36;
  bram_pkg::bram_width_t wb    = bram_pkg::BRAM_W36;
  logic                  oreg  = 1'b0;
  bram_pkg::bram_req_t   req_a;
  bram_pkg::bram_req_t   req_b;
  logic [35:0]           rdata_a;
  logic [35:0]           rdata_b;
  logic                  rvalid_a;
  logic                  rvalid_b;
  logic                  fifo_full;
  logic                  fifo_empty;
  int                    err_total   = 0;
  int                    check_count = 0;

  always #5 mclk = ~mclk;

  bram_fabric fab (.req_a(req_a), .req_b(req_b));

  bram_block #(.INIT_BITS(9216'hA5C3)) DUT (
    .mclk(mclk), .rst_n(rst_n), .mode(mode), .width_a(wa), .width_b(wb),
    .out_reg_en(oreg), .req_a(req_a), .req_b(req_b), .rdata_a(rdata_a),
    .rvalid_a(rvalid_a), .rdata_b(rdata_b), .rvalid_b(rvalid_b),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty)
  );

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // mode and widths only change while reset is held; memory keeps its contents
  task automatic setup(input bram_pkg::bram_mode_t m, input bram_pkg::bram_width_t a,
                       input bram_pkg::bram_width_t b, input logic o);
    @(negedge mclk);
    rst_n = 1'b0;
    mode  = m;
    wa    = a;
    wb    = b;
    oreg  = o;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
  endtask

  // a read is judged at every edge from the second up to its answer, so early data fails too
  task automatic access(input logic p, input logic we, input logic [12:0] ad,
                        input logic [35:0] d, input int lat);
    @(negedge mclk);
    fab.drive(p, we, ad, d);
    @(negedge mclk);
    fab.rel();
    // edge one captured the request and is already behind us
    if (!we) for (int k = 2; k <= lat; k++) begin
      @(posedge mclk);
      #1;
      check(36'(p ? rvalid_b : rvalid_a), 36'(k == lat));
      if (k == lat) check(p ? rdata_b : rdata_a, d);
    end
  endtask

  task automatic s_preload();
    logic [35:0] m;
    for (int i = 0; i < 6; i++) begin
      m = (36'h1 << WB[i]) - 36'h1;
      setup(bram_pkg::BRAM_MODE_SINGLE, bram_pkg::bram_width_t'(i), bram_pkg::BRAM_W36, 1'b0);
      access(1'b0, 1'b0, 13'h0000, INIT_LOW & m, 2);
      access(1'b0, 1'b0, 13'h0001, (INIT_LOW >> WB[i]) & m, 2);
    end
  endtask

  task automatic s_latency();
    setup(bram_pkg::BRAM_MODE_SINGLE, bram_pkg::BRAM_W9, bram_pkg::BRAM_W9, 1'b0);
    access(1'b0, 1'b1, 13'h0005, 36'h1A5, 2);
    access(1'b1, 1'b1, 13'h0005, 36'h0, 2);
    access(1'b0, 1'b0, 13'h0005, 36'h1A5, 2);
    setup(bram_pkg::BRAM_MODE_SINGLE, bram_pkg::BRAM_W9, bram_pkg::BRAM_W9, 1'b1);
    access(1'b0, 1'b0, 13'h0005, 36'h1A5, 3);
  endtask

  task automatic s_mixed();
    setup(bram_pkg::BRAM_MODE_PSEUDO_DUAL, bram_pkg::BRAM_W9, bram_pkg::BRAM_W18, 1'b0);
    access(1'b0, 1'b1, 13'h0003, 36'h155, 2);
    access(1'b1, 1'b0, 13'h0001, 36'h2AA00, 2);
    access(1'b1, 1'b1, 13'h0001, 36'h0, 2);
    access(1'b1, 1'b0, 13'h0001, 36'h2AA00, 2);
  endtask

  task automatic s_dual();
    setup(bram_pkg::BRAM_MODE_TRUE_DUAL, bram_pkg::BRAM_W36, bram_pkg::BRAM_W18, 1'b0);
    @(negedge mclk);
    fab.drive(1'b0, 1'b1, 13'h000A, 36'hF002BCDE);
    fab.drive(1'b1, 1'b1, 13'h000B, 36'h13579);
    @(negedge mclk);
    fab.drive(1'b0, 1'b0, 13'h000B, 36'h0);
    fab.drive(1'b1, 1'b0, 13'h000A, 36'h0);
    @(negedge mclk);
    fab.rel();
    @(posedge mclk);
    #1;
    check(36'({rvalid_a, rvalid_b}), 36'h3);
    check(rdata_a, 36'h13579);
    check(rdata_b, 36'h2BCDE);
    @(negedge mclk);
    fab.req_a.rst = 1'b1;
    @(negedge mclk);
    fab.req_a.rst = 1'b0;
    check(rdata_a, 36'h0);
    check(rdata_b, 36'h2BCDE);
  endtask

  // one push past full and four pops past empty must leave no trace
  task automatic s_fifo();
    int n;
    n = 0;
    setup(bram_pkg::BRAM_MODE_FIFO, bram_pkg::BRAM_W36, bram_pkg::BRAM_W36, 1'b0);
    check(36'({fifo_empty, fifo_full}), 36'h2);
    for (int i = 0; i < 257; i++) begin
      @(negedge mclk);
      fab.drive(1'b0, 1'b1, 13'h0000, 36'h100 + 36'(i));
    end
    @(negedge mclk);
    fab.rel();
    repeat (2) @(negedge mclk);
    check(36'({fifo_empty, fifo_full}), 36'h1);
    for (int i = 0; i < 266; i++) begin
      @(negedge mclk);
      if (rvalid_b === 1'b1) begin
        check(rdata_b, 36'h100 + 36'(n));
        n++;
      end
      if (i < 260) fab.drive(1'b1, 1'b0, 13'h0000, 36'h0);
      else fab.rel();
    end
    check(36'(n), 36'h100);
    check(36'({fifo_empty, fifo_full}), 36'h2);
  endtask

  initial begin
    #50000;
    err_total++;
    test_done();
  end

  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    s_preload();
    s_latency();
    s_mixed();
    s_dual();
    s_fifo();
    test_done();
  end
endmodule // tb_top
